// *** logic/port_b_swap_parity_path.sv ***
/*
 * mailboxes, port-b sizing with byte swap, parity check and parity generation on both ports.
 * assumes one clock for both ports and queue rams outside with same-cycle read data.
 */
`timescale 1ns/100ps
module port_b_swap_parity_path (
	// clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst_n,
	// shared parity sense
	input  wire logic                               odd_even_sel,
	// port a controls
	input  wire logic                               porta_select_n,
	input  wire logic                               porta_xfer_en,
	input  wire logic                               porta_write_sel,
	input  wire logic                               porta_mail_sel,
	input  wire logic                               porta_par_gen,
	// port a data pins
	input  wire logic [swap_parity_pkg::DATA_W-1:0] porta_data_in,
	output logic      [swap_parity_pkg::DATA_W-1:0] porta_data_out,
	output logic                                    porta_data_oe,
	output logic                                    porta_par_err_n,
	// port b controls
	input  wire logic                               portb_select_n,
	input  wire logic                               portb_xfer_en,
	input  wire logic                               portb_write_sel,
	input  wire logic                               portb_width_sel0,
	input  wire logic                               portb_width_sel1,
	input  wire logic                               big_endian_sel,
	input  wire logic                               swap_sel0,
	input  wire logic                               swap_sel1,
	input  wire logic                               portb_par_gen,
	// port b data pins
	input  wire logic [swap_parity_pkg::DATA_W-1:0] portb_data_in,
	output logic      [swap_parity_pkg::DATA_W-1:0] portb_data_out,
	output logic                                    portb_data_oe,
	output logic                                    portb_par_err_n,
	// registered port-b selection
	output logic                                    portb_width_sel0_reg,
	output logic                                    portb_width_sel1_reg,
	output logic                                    portb_endian_reg,
	// mailbox flags
	output logic                                    fwd_mail_flag_n,
	output logic                                    rev_mail_flag_n,
	// forward queue ram side
	output logic                                    fwd_queue_wr_en,
	output logic      [swap_parity_pkg::DATA_W-1:0] fwd_queue_wr_data,
	output logic                                    fwd_queue_rd_req,
	input  wire logic [swap_parity_pkg::DATA_W-1:0] fwd_queue_rd_data,
	// reverse queue ram side
	output logic                                    rev_queue_wr_en,
	output logic      [swap_parity_pkg::DATA_W-1:0] rev_queue_wr_data,
	output logic                                    rev_queue_rd_req,
	input  wire logic [swap_parity_pkg::DATA_W-1:0] rev_queue_rd_data
);
	import swap_parity_pkg::*;

	// ******************************
	// state
	// ******************************
	logic [DATA_W-1:0] fwd_mailbox_ff, rev_mailbox_ff;
	logic              fwd_flag_ff, rev_flag_ff;
	width_t            width_ff;
	logic              endian_ff;
	logic [DATA_W-1:0] a_out_ff, b_out_ff;
	logic [DATA_W-1:0] rd_aux_ff, wr_aux_ff;
	piece_t            rd_piece_ff, wr_piece_ff;
	width_t            rd_width_ff, wr_width_ff;
	swap_t             wr_swap_ff;
	logic              fq_wr_ff, rq_wr_ff;
	logic [DATA_W-1:0] fq_data_ff, rq_data_ff;
	// ******************************
	// port a decode
	// ******************************
	wire logic a_act     = ~porta_select_n & porta_xfer_en;
	wire logic a_rd      = a_act & ~porta_write_sel;
	wire logic a_wr      = a_act & porta_write_sel;
	wire logic a_mail_rd = a_rd & porta_mail_sel;
	wire logic a_mail_wr = a_wr & porta_mail_sel;
	wire logic a_q_rd    = a_rd & ~porta_mail_sel;
	wire logic a_q_wr    = a_wr & ~porta_mail_sel;
	wire logic a_mail_gen = a_mail_rd & porta_par_gen;
	// ******************************
	// port b decode: raw selects pick the mailbox at once
	// ******************************
	wire width_t raw_width = {portb_width_sel1, portb_width_sel0};
	wire logic   b_mail    = (raw_width == WIDTH_MAIL);
	wire logic   b_act     = ~portb_select_n & portb_xfer_en;
	wire logic   b_rd      = b_act & ~portb_write_sel;
	wire logic   b_wr      = b_act & portb_write_sel;
	wire logic   b_mail_rd = b_rd & b_mail;
	wire logic   b_mail_wr = b_wr & b_mail;
	wire logic   b_q_rd    = b_rd & ~b_mail;
	wire logic   b_q_wr    = b_wr & ~b_mail;
	wire logic   b_mail_gen = b_mail_rd & portb_par_gen;
	wire swap_t  raw_swap  = {swap_sel1, swap_sel0};
	// ******************************
	// parity trees: port pins, shared with mailbox generation
	// ******************************
	logic [DATA_W-1:0]    a_tree_gen, b_tree_gen, fq_gen, rq_gen;
	logic [NUM_LANES-1:0] a_tree_fail, b_tree_fail;

	// trees see the pins unless a mailbox read with generation borrows them
	wire logic [DATA_W-1:0] a_tree_in = a_mail_gen ? rev_mailbox_ff : porta_data_in;
	wire logic [DATA_W-1:0] b_tree_in = b_mail_gen ? fwd_mailbox_ff : portb_data_in;

	parity_trees u_a_trees (
		.data_in   (a_tree_in),
		.odd_sel   (odd_even_sel),
		.gen_en    (porta_par_gen),
		.gen_data  (a_tree_gen),
		.byte_fail (a_tree_fail)
	);
	parity_trees u_b_trees (
		.data_in   (b_tree_in),
		.odd_sel   (odd_even_sel),
		.gen_en    (portb_par_gen),
		.gen_data  (b_tree_gen),
		.byte_fail (b_tree_fail)
	);
	// queue paths generate between ram read and output register
	parity_trees u_fq_trees (
		.data_in   (fwd_queue_rd_data),
		.odd_sel   (odd_even_sel),
		.gen_en    (portb_par_gen),
		.gen_data  (fq_gen),
		.byte_fail ()
	);
	parity_trees u_rq_trees (
		.data_in   (rev_queue_rd_data),
		.odd_sel   (odd_even_sel),
		.gen_en    (porta_par_gen),
		.gen_data  (rq_gen),
		.byte_fail ()
	);
	// ******************************
	// sizing position for the current long word
	// ******************************
	wire logic   rd_new  = (rd_piece_ff == FIRST_PIECE) | (rd_width_ff != width_ff);
	wire piece_t rd_k    = rd_new ? FIRST_PIECE : rd_piece_ff;
	wire logic   rd_last = (rd_k == last_piece(width_ff));
	wire logic   wr_new  = (wr_piece_ff == FIRST_PIECE) | (wr_width_ff != width_ff);
	wire piece_t wr_k    = wr_new ? FIRST_PIECE : wr_piece_ff;
	wire logic   wr_last = (wr_k == last_piece(width_ff));
	// a new word is swapped as it leaves the ram, before splitting
	wire logic [DATA_W-1:0] rd_loaded = swap_bytes(fq_gen, raw_swap);
	wire logic [DATA_W-1:0] rd_word   = rd_new ? rd_loaded : rd_aux_ff;
	wire swap_t             wr_swap   = wr_new ? raw_swap : wr_swap_ff;
	// ******************************
	// lane mapping per port-b lane
	// ******************************
	logic [NUM_LANES-1:0] lane_on;
	logic [DATA_W-1:0]    b_lanes_rd;
	logic [NUM_LANES-1:0] b_fail_valid;

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_lane
			wire logic [1:0] rsrc = lane_src(width_ff, endian_ff, rd_k, 2'(g));
			assign lane_on[g] = lane_used(width_ff, endian_ff, 2'(g));
			assign b_lanes_rd[g*BYTE_W +: BYTE_W] = rd_word[rsrc*BYTE_W +: BYTE_W];
			assign b_fail_valid[g] = b_tree_fail[g] & lane_on[g];
		end
	endgenerate

	// write assembly: incoming lanes drop into their long-word byte
	logic [DATA_W-1:0] wr_asm;
	logic [1:0]        wsrc;
	always_comb begin
		wr_asm = wr_new ? RST_DATA : wr_aux_ff;
		wsrc   = 2'h0;
		for (int i = 0; i < NUM_LANES; i++) begin
			wsrc = lane_src(width_ff, endian_ff, wr_k, 2'(i));
			if (lane_on[i]) begin
				wr_asm[wsrc*BYTE_W +: BYTE_W] = portb_data_in[i*BYTE_W +: BYTE_W];
			end
		end
	end
	// ******************************
	// width and endian registers: held across mailbox access
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			width_ff  <= RST_WIDTH;
			endian_ff <= RST_ENDIAN;
		end else if (!b_mail) begin
			width_ff  <= raw_width;
			endian_ff <= big_endian_sel;
		end
	end
	// ******************************
	// mailboxes and their flags
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fwd_mailbox_ff <= RST_DATA;
			rev_mailbox_ff <= RST_DATA;
			fwd_flag_ff    <= RST_MAIL_FLAG;
			rev_flag_ff    <= RST_MAIL_FLAG;
		end else begin
			if (a_mail_wr && fwd_flag_ff) begin
				fwd_mailbox_ff <= porta_data_in;
				fwd_flag_ff    <= 1'b0;
			end else if (b_mail_rd) begin
				fwd_flag_ff <= 1'b1;
			end
			if (b_mail_wr && rev_flag_ff) begin
				rev_mailbox_ff <= portb_data_in;
				rev_flag_ff    <= 1'b0;
			end else if (a_mail_rd) begin
				rev_flag_ff <= 1'b1;
			end
		end
	end
	// ******************************
	// port a output register
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			a_out_ff <= RST_DATA;
		end else if (a_mail_rd) begin
			a_out_ff <= a_mail_gen ? a_tree_gen : rev_mailbox_ff;
		end else if (a_q_rd) begin
			a_out_ff <= rq_gen;
		end
	end
	// ******************************
	// port b output register: unused lanes hold their last value
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			b_out_ff <= RST_DATA;
		end else if (b_mail_rd) begin
			b_out_ff <= b_mail_gen ? b_tree_gen : fwd_mailbox_ff;
		end else if (b_q_rd) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				if (lane_on[i]) begin
					b_out_ff[i*BYTE_W +: BYTE_W] <= b_lanes_rd[i*BYTE_W +: BYTE_W];
				end
			end
		end
	end
	// ******************************
	// forward-queue read sequencing
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_aux_ff   <= RST_DATA;
			rd_piece_ff <= FIRST_PIECE;
			rd_width_ff <= RST_WIDTH;
		end else if (b_q_rd) begin
			rd_aux_ff   <= rd_word;
			rd_width_ff <= width_ff;
			rd_piece_ff <= rd_last ? FIRST_PIECE : rd_k + PIECE_STEP;
		end
	end
	// ******************************
	// reverse-queue write assembly
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_aux_ff   <= RST_DATA;
			wr_piece_ff <= FIRST_PIECE;
			wr_width_ff <= RST_WIDTH;
			wr_swap_ff  <= RST_SWAP;
		end else if (b_q_wr) begin
			wr_aux_ff   <= wr_asm;
			wr_width_ff <= width_ff;
			wr_swap_ff  <= wr_swap;
			wr_piece_ff <= wr_last ? FIRST_PIECE : wr_k + PIECE_STEP;
		end
	end
	// ******************************
	// queue write ports, one cycle after the taking edge
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fq_wr_ff   <= 1'b0;
			fq_data_ff <= RST_DATA;
			rq_wr_ff   <= 1'b0;
			rq_data_ff <= RST_DATA;
		end else begin
			fq_wr_ff <= a_q_wr;
			rq_wr_ff <= b_q_wr & wr_last;
			if (a_q_wr) begin
				fq_data_ff <= porta_data_in;
			end
			if (b_q_wr && wr_last) begin
				rq_data_ff <= swap_bytes(wr_asm, wr_swap);
			end
		end
	end
	// ******************************
	// outputs
	// ******************************
	assign porta_data_out       = a_out_ff;
	assign portb_data_out       = b_out_ff;
	assign porta_data_oe        = ~porta_select_n & ~porta_write_sel;
	assign portb_data_oe        = ~portb_select_n & ~portb_write_sel;
	assign porta_par_err_n      = a_mail_gen | ~(|a_tree_fail);
	assign portb_par_err_n      = b_mail_gen | ~(|b_fail_valid);
	assign portb_width_sel0_reg = width_ff[0];
	assign portb_width_sel1_reg = width_ff[1];
	assign portb_endian_reg     = endian_ff;
	assign fwd_mail_flag_n      = fwd_flag_ff;
	assign rev_mail_flag_n      = rev_flag_ff;
	assign fwd_queue_wr_en      = fq_wr_ff;
	assign fwd_queue_wr_data    = fq_data_ff;
	assign fwd_queue_rd_req     = b_q_rd & rd_new;
	assign rev_queue_wr_en      = rq_wr_ff;
	assign rev_queue_wr_data    = rq_data_ff;
	assign rev_queue_rd_req     = a_q_rd;

endmodule

// *** include/swap_parity_pkg.sv ***
/*
 * shared constants, types and helper functions for the port-b swap and parity path.
 * assumes byte lanes of nine bits, four lanes to a long word, lane 3 the most significant.
 */
package swap_parity_pkg;

	// ************************************************************
	// data layout
	// ************************************************************
	localparam int BYTE_W    = 9;
	localparam int NUM_LANES = 4;
	localparam int DATA_W    = BYTE_W * NUM_LANES;
	localparam int PAR_BIT   = BYTE_W - 1;

	typedef logic [1:0] width_t;
	typedef logic [1:0] swap_t;
	typedef logic [1:0] piece_t;

	// ************************************************************
	// port-b width codes as {width_sel1, width_sel0}
	// ************************************************************
	localparam width_t WIDTH_LONG = 2'h0;
	localparam width_t WIDTH_WORD = 2'h1;
	localparam width_t WIDTH_BYTE = 2'h2;
	localparam width_t WIDTH_MAIL = 2'h3;

	localparam piece_t LAST_LONG = 2'h0;
	localparam piece_t LAST_WORD = 2'h1;
	localparam piece_t LAST_BYTE = 2'h3;
	localparam piece_t FIRST_PIECE = 2'h0;
	localparam piece_t PIECE_STEP  = 2'h1;
	localparam logic [1:0] TOP_LANE  = 2'h3;
	localparam logic [1:0] HALF_LANE = 2'h2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic   RST_MAIL_FLAG = 1'b1;
	localparam width_t RST_WIDTH     = WIDTH_LONG;
	localparam logic   RST_ENDIAN    = 1'b1;
	localparam swap_t  RST_SWAP      = 2'h0;
	localparam logic [DATA_W-1:0] RST_DATA = 36'h0;

	// last piece index for a width
	function automatic piece_t last_piece(input width_t w);
		case (w)
			WIDTH_WORD: last_piece = LAST_WORD;
			WIDTH_BYTE: last_piece = LAST_BYTE;
			default:    last_piece = LAST_LONG;
		endcase
	endfunction

	// whether a port-b lane carries data for this width and endianness
	function automatic logic lane_used(input width_t w, input logic be, input logic [1:0] lane);
		case (w)
			WIDTH_WORD: lane_used = be ? (lane >= HALF_LANE) : (lane < HALF_LANE);
			WIDTH_BYTE: lane_used = be ? (lane == TOP_LANE) : (lane == FIRST_PIECE);
			default:    lane_used = 1'b1;
		endcase
	endfunction

	// long-word byte that a port-b lane carries for piece k
	function automatic logic [1:0] lane_src(input width_t w, input logic be, input piece_t k,
		input logic [1:0] lane);
		case (w)
			WIDTH_WORD: lane_src = be ? lane - {k[0], 1'b0} : lane + {k[0], 1'b0};
			WIDTH_BYTE: lane_src = be ? TOP_LANE - k : k;
			default:    lane_src = lane;
		endcase
	endfunction

	// whole-byte reordering: lane i takes byte i xor mask
	function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] d, input swap_t code);
		logic [1:0] mask;
		logic [1:0] src;
		swap_bytes = d;
		mask = {code[1] ^ code[0], code[0]};
		for (int i = 0; i < NUM_LANES; i++) begin
			src = 2'(i) ^ mask;
			swap_bytes[i*BYTE_W +: BYTE_W] = d[src*BYTE_W +: BYTE_W];
		end
	endfunction

endpackage

// *** logic/parity_trees.sv ***
/*
 * four parity trees over one 36-bit port: per-byte check and parity generation.
 * assumes the caller picks what the trees look at (pins or stored data).
 */
`timescale 1ns/100ps
module parity_trees (
	// data seen by the trees
	input  wire logic [swap_parity_pkg::DATA_W-1:0]    data_in,
	// odd sense when high, even when low
	input  wire logic                                  odd_sel,
	// substitute generated parity bits when high
	input  wire logic                                  gen_en,
	// results
	output logic      [swap_parity_pkg::DATA_W-1:0]    gen_data,
	output logic      [swap_parity_pkg::NUM_LANES-1:0] byte_fail
);
	import swap_parity_pkg::*;

	// ************************************************************
	// one tree per byte
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_tree
			wire logic [BYTE_W-1:0] byte_w = data_in[g*BYTE_W +: BYTE_W];
			wire logic              low_x  = ^byte_w[PAR_BIT-1:0];
			wire logic              gen_p  = odd_sel ? ~low_x : low_x;
			// fail when all nine bits xor even (odd sense) or odd (even sense)
			assign byte_fail[g] = odd_sel ? ~(^byte_w) : (^byte_w);
			assign gen_data[g*BYTE_W +: BYTE_W] =
				{(gen_en ? gen_p : byte_w[PAR_BIT]), byte_w[PAR_BIT-1:0]};
		end
	endgenerate

endmodule

// *** test/port_b_swap_parity_path_chk.sv ***
/*
 * assertions on parity flags, their forcing, the forward mail flag and the select registers.
 * assumes binding to the top module; sees only its ports, all on sys_clk.
 */
`timescale 1ns/100ps
module port_b_swap_parity_path_chk
	import swap_parity_pkg::*;
(
	// clock, reset and parity sense
	input wire logic                               sys_clk, rst_n, odd_even_sel,
	// port a
	input wire logic                               porta_select_n, porta_xfer_en, porta_write_sel,
	input wire logic                               porta_mail_sel, porta_par_gen, porta_par_err_n,
	input wire logic [swap_parity_pkg::DATA_W-1:0] porta_data_in, porta_data_out,
	// port b
	input wire logic                               portb_select_n, portb_xfer_en, portb_write_sel,
	input wire logic                               portb_width_sel0, portb_width_sel1, big_endian_sel,
	input wire logic                               portb_par_gen, portb_par_err_n,
	input wire logic [swap_parity_pkg::DATA_W-1:0] portb_data_in,
	// registered selection and flags
	input wire logic                               portb_width_sel0_reg, portb_width_sel1_reg, portb_endian_reg,
	input wire logic                               fwd_mail_flag_n, rev_queue_wr_en
);
	// ************************************************************
	// helpers
	// ************************************************************
	// per-byte failure under the selected sense
	function automatic logic [3:0] bad(input logic [DATA_W-1:0] d, input logic s);
		for (int i = 0; i < NUM_LANES; i++) bad[i] = (^(~d[i*BYTE_W +: BYTE_W])) == s;
	endfunction
	// every top bit equals the parity made from the lower eight
	function automatic logic gen_ok(input logic [DATA_W-1:0] d, input logic s);
		gen_ok = 1'b1;
		for (int i = 0; i < NUM_LANES; i++) if (d[i*BYTE_W+PAR_BIT] != (s ^ (^d[i*BYTE_W +: PAR_BIT]))) gen_ok = 1'b0;
	endfunction
	// lanes that count for the implemented width
	function automatic logic [3:0] vmask(input logic w1, input logic w0, input logic be);
		case ({w1, w0})
			2'h1: vmask = be ? 4'hc : 4'h3;
			2'h2: vmask = be ? 4'h8 : 4'h1;
			default: vmask = 4'hf;
		endcase
	endfunction
	// selected accesses
	wire logic b_mail = portb_width_sel0 && portb_width_sel1;
	wire logic a_mrd = !porta_select_n && porta_xfer_en && !porta_write_sel && porta_mail_sel;
	wire logic a_mwr = !porta_select_n && porta_xfer_en && porta_write_sel && porta_mail_sel;
	wire logic b_mrd = !portb_select_n && portb_xfer_en && !portb_write_sel && b_mail;
	wire logic [3:0] b_fail = bad(portb_data_in, odd_even_sel) & vmask(portb_width_sel1_reg, portb_width_sel0_reg,
		portb_endian_reg);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ************************************************************
	// assertions
	// ************************************************************
	property p_a_force; a_mrd && porta_par_gen |-> porta_par_err_n; endproperty
	a_a_force: assert property (p_a_force) else $error("port a flag low on mailbox read");
	property p_b_force; b_mrd && portb_par_gen |-> portb_par_err_n; endproperty
	a_b_force: assert property (p_b_force) else $error("port b flag low on mailbox read");
	property p_a_check; !(a_mrd && porta_par_gen) |-> porta_par_err_n == !(|bad(porta_data_in, odd_even_sel)); endproperty
	a_a_check: assert property (p_a_check) else $error("port a parity flag wrong");
	property p_b_check; !b_mail |-> portb_par_err_n == !(|b_fail); endproperty
	a_b_check: assert property (p_b_check) else $error("port b parity flag wrong");
	property p_flag; b_mrd && !a_mwr |=> fwd_mail_flag_n; endproperty
	a_flag: assert property (p_flag) else $error("forward mail flag not set");
	property p_reg; !b_mail |=> {portb_width_sel1_reg, portb_width_sel0_reg, portb_endian_reg} ==
		$past({portb_width_sel1, portb_width_sel0, big_endian_sel}); endproperty
	a_reg: assert property (p_reg) else $error("width selects not registered");
	property p_keep; b_mail |=> $stable({portb_width_sel1_reg, portb_width_sel0_reg}); endproperty
	a_keep: assert property (p_keep) else $error("mailbox access changed stored width");
	property p_gen; a_mrd && porta_par_gen |=> gen_ok(porta_data_out, $past(odd_even_sel)); endproperty
	a_gen: assert property (p_gen) else $error("port a mailbox parity not generated");

	// main scenarios
	c_b_mail: cover property (b_mrd && portb_par_gen);
	c_a_gen: cover property (a_mrd && porta_par_gen);
	c_rev_store: cover property (rev_queue_wr_en);
endmodule

bind port_b_swap_parity_path port_b_swap_parity_path_chk chk (.*);

// *** test/queue_ram_model.sv ***
/*
 * queue ram stand-in: combinational read data in the request cycle, captures stored long words.
 * assumes the bench sets head to the word the queue holds next.
 */
`timescale 1ns/100ps
module queue_ram_model (
	// clock and next word
	input  wire logic        sys_clk,
	input  wire logic [35:0] head,
	// read sides
	input  wire logic        fwd_queue_rd_req,
	output logic      [35:0] fwd_queue_rd_data,
	input  wire logic        rev_queue_rd_req,
	output logic      [35:0] rev_queue_rd_data,
	// reverse queue store
	input  wire logic        rev_queue_wr_en,
	input  wire logic [35:0] rev_queue_wr_data,
	output logic      [35:0] last_wr
);
	// data is only good in the request cycle, garbage otherwise
	assign fwd_queue_rd_data = fwd_queue_rd_req ? head : ~head;
	assign rev_queue_rd_data = rev_queue_rd_req ? head : ~head;
	// keep the last stored long word
	always_ff @(posedge sys_clk) begin
		if (rev_queue_wr_en) begin
			last_wr <= rev_queue_wr_data;
		end
	end
endmodule

// *** test/test_port_b_swap_parity_path.sv ***
/*
 * self-checking bench: mailboxes, swapped and sized queue traffic, parity generation, refused writes.
 * assumes the checker is bound to the design and the ram model answers on the queue side.
 */
`timescale 1ns/100ps
module test_port_b_swap_parity_path;
	import swap_parity_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	logic              sys_clk, rst_n, odd_even_sel, s;
	logic              porta_select_n, porta_xfer_en, porta_write_sel, porta_mail_sel, porta_par_gen;
	logic              portb_select_n, portb_xfer_en, portb_write_sel, portb_par_gen, big_endian_sel;
	logic              portb_width_sel0, portb_width_sel1, swap_sel0, swap_sel1, porta_data_oe, portb_data_oe;
	logic              porta_par_err_n, portb_par_err_n, portb_width_sel0_reg, portb_width_sel1_reg;
	logic              portb_endian_reg, fwd_mail_flag_n, rev_mail_flag_n, fwd_queue_rd_req, rev_queue_rd_req;
	logic              fwd_queue_wr_en, rev_queue_wr_en;
	logic [DATA_W-1:0] pa_drv, pb_drv, head, last_wr, porta_data_out, portb_data_out, w, v;
	logic [DATA_W-1:0] fwd_queue_wr_data, rev_queue_wr_data, fwd_queue_rd_data, rev_queue_rd_data;
	wire  [DATA_W-1:0] porta_data_in, portb_data_in;
	logic [31:0]       seed;
	int                err_count, checks;

	port_b_swap_parity_path dut (.*);
	queue_ram_model ram (.*);
	// pins carry the block's data while it drives, the bench's otherwise
	assign porta_data_in = porta_data_oe ? porta_data_out : pa_drv;
	assign portb_data_in = portb_data_oe ? portb_data_out : pb_drv;
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [35:0] word();
		logic [31:0] h;
		h = rnd();
		return {h[3:0], rnd()};
	endfunction
	// lane i takes byte i xor mask
	function automatic logic [35:0] swp(input logic [35:0] d, input logic [1:0] c);
		logic [1:0] m;
		m = {c[1] ^ c[0], c[0]};
		for (int i = 0; i < 4; i++) swp[i*9 +: 9] = d[(2'(i) ^ m)*9 +: 9];
	endfunction
	// top bit of each byte replaced by parity of the lower eight
	function automatic logic [35:0] pgen(input logic [35:0] d, input logic o);
		pgen = d;
		for (int i = 0; i < 4; i++) pgen[i*9+8] = o ^ (^d[i*9 +: 8]);
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// port a transfer: request one edge, taken at the next
	task automatic pa(input logic wr, input logic mail, input logic gen, input logic [35:0] d);
		@(posedge sys_clk);
		{porta_select_n, porta_xfer_en, porta_write_sel, porta_mail_sel, porta_par_gen} <= {2'b01, wr, mail, gen};
		pa_drv <= d;
		@(posedge sys_clk);
		{porta_select_n, porta_xfer_en} <= 2'b10;
		#1;
	endtask
	// port b transfer, c = {gen, swap, endian, width}; selects lead by one edge so they are registered
	task automatic pb(input logic wr, input logic [5:0] c, input logic [35:0] d);
		@(posedge sys_clk);
		{portb_par_gen, swap_sel1, swap_sel0, big_endian_sel, portb_width_sel1, portb_width_sel0} <= c;
		{portb_write_sel, pb_drv} <= {wr, d};
		@(posedge sys_clk);
		{portb_select_n, portb_xfer_en} <= 2'b01;
		@(posedge sys_clk);
		{portb_select_n, portb_xfer_en} <= 2'b10;
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{porta_select_n, portb_select_n, big_endian_sel, rst_n} = 4'he;
		{porta_xfer_en, porta_write_sel, porta_mail_sel, porta_par_gen, odd_even_sel} = 5'h0;
		{portb_xfer_en, portb_write_sel, portb_par_gen, portb_width_sel0, portb_width_sel1} = 5'h0;
		{swap_sel0, swap_sel1, pa_drv, pb_drv, head} = 110'h0;
		{seed, err_count, checks} = {32'h78d0b98b, 64'h0};
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk1(fwd_mail_flag_n & rev_mail_flag_n, RST_MAIL_FLAG);
		chk({portb_width_sel1_reg, portb_width_sel0_reg, portb_endian_reg}, {RST_WIDTH, RST_ENDIAN});
		for (int i = 0; i < 4; i++) begin
			w = word();
			s = w[35];
			@(posedge sys_clk);
			odd_even_sel <= s;
			// forward mailbox round trip with a swap code set
			pa(1'b1, 1'b1, 1'b0, w);
			chk1(fwd_mail_flag_n, 1'b0);
			pb(1'b0, {i[1], 2'(i), 3'h3}, ~w);
			chk(portb_data_out, i[1] ? pgen(w, s) : w);
			chk1(fwd_mail_flag_n, 1'b1);
			// long word read with every swap code
			head = w;
			pb(1'b0, {i[0], 2'(i), 3'h0}, w);
			chk(portb_data_out, i[0] ? pgen(swp(w, 2'(i)), s) : swp(w, 2'(i)));
			// byte reads in either endian, swap changed after the first, mailbox read between
			v = word();
			head = v;
			w = swp(v, 2'(i));
			for (int k = 0; k < 4; k++) begin
				if (k == 2) pb(1'b0, 6'h03, v);
				pb(1'b0, {1'b0, k == 0 ? 2'(i) : ~2'(i), i[0], 2'h2}, v);
				chk(i[0] ? portb_data_out[35:27] : portb_data_out[8:0], w[(i[0] ? 3 - k : k)*9 +: 9]);
			end
			// word writes in either endian, assembled then swapped
			v = word();
			w = word();
			pb(1'b1, {1'b0, 2'(i), i[1], 2'h1}, v);
			pb(1'b1, {1'b0, ~2'(i), i[1], 2'h1}, w);
			chk1(rev_queue_wr_en, 1'b1);
			@(posedge sys_clk);
			#1;
			chk(last_wr, swp(i[1] ? {v[35:18], w[35:18]} : {w[17:0], v[17:0]}, 2'(i)));
			// reverse mailbox: second write refused, generation leaves contents alone
			v = word();
			pb(1'b1, 6'h03, v);
			pb(1'b1, 6'h03, ~v);
			chk1(rev_mail_flag_n, 1'b0);
			pa(1'b0, 1'b1, 1'b0, w);
			chk(porta_data_out, v);
			pa(1'b0, 1'b1, 1'b1, w);
			chk(porta_data_out, pgen(v, s));
			pa(1'b0, 1'b1, 1'b0, w);
			chk(porta_data_out, v);
			// port a queue read with generation, then queue write
			head = w;
			pa(1'b0, 1'b0, 1'b1, v);
			chk(porta_data_out, pgen(w, s));
			pa(1'b1, 1'b0, 1'b1, v);
			chk1(fwd_queue_wr_en, 1'b1);
			chk(fwd_queue_wr_data, v);
		end
		close_out();
	end
	// watchdog: about twelve times the run
	initial begin
		#20000;
		err_count++;
		close_out();
	end
endmodule
